// *** common/midi_map.svh ***
// constants of the midi message interpreter
`ifndef MIDI_MAP_SVH
`define MIDI_MAP_SVH
// status nibbles of channel and system messages
`define MIDI_NOTE_OFF 4'h8
`define MIDI_NOTE_ON 4'h9
`define MIDI_CTRL 4'hb
`define MIDI_PROG 4'hc
`define MIDI_PRESS 4'hd
`define MIDI_SYSTEM 4'hf
// system status bytes
`define MIDI_SX_START 8'hf0
`define MIDI_TC_QUARTER 8'hf1
`define MIDI_SONG_POS 8'hf2
`define MIDI_SONG_SEL 8'hf3
`define MIDI_SX_END 8'hf7
`define MIDI_RT_PREFIX 5'h1f
`define MIDI_CLOCK 8'hf8
`define MIDI_START 8'hfa
`define MIDI_CONTINUE 8'hfb
`define MIDI_STOP 8'hfc
// controller numbers
`define CC_LSB_FIRST 7'h20
`define CC_LSB_LAST 7'h3f
`define CC_SWITCH_FIRST 7'h40
`define CC_SWITCH_LAST 7'h45
`define CC_DATA_INC 7'h60
`define CC_DATA_DEC 7'h61
`define CC_NRPN_MSB 7'h62
`define CC_NRPN_LSB 7'h63
`define CC_RPN_MSB 7'h64
`define CC_RPN_LSB 7'h65
`define CC_MODE_FIRST 7'h79
`define CC_RESET_ALL 7'h79
`define CC_LOCAL 7'h7a
`define CC_ALL_OFF 7'h7b
`define CC_OMNI_OFF 7'h7c
`define CC_OMNI_ON 7'h7d
`define CC_MONO_ON 7'h7e
`define CC_POLY_ON 7'h7f
// values
`define MIDI_VAL_MAX 7'h7f
`define MIDI_VEL_OFF 7'h00
`define MIDI_MIDDLE_C 7'h3c
`define MIDI_MONO_MAX 7'h10
// timing clock: 24 per quarter, 4 sixteenth beats per quarter
`define MIDI_CLK_PER_QN 24
`define MIDI_BEATS_PER_QN 4
`endif

// *** common/midi_pkg.sv ***
// types shared by the midi message interpreter
package midi_pkg;
  typedef enum logic [1:0] {sx_idle, sx_id, sx_take, sx_skip} sx_state_t;
  typedef enum logic [2:0] {par_nrpn_msb, par_nrpn_lsb, par_rpn_msb, par_rpn_lsb, par_inc, par_dec} param_sel_t;
  typedef enum logic [2:0] {mode_reset_all, mode_local, mode_all_off, mode_omni_off, mode_omni_on, mode_mono_on,
    mode_poly_on} mode_cmd_t;
endpackage : midi_pkg

// *** verilog/byte_fifo.sv ***
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // depth need not be a power of two, so pointers wrap explicitly
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// *** verilog/midi_message_interpreter.sv ***
// midi receive message interpreter with thru echo
`timescale 1ns/1ps
`include "midi_map.svh"
// Contract
// - note numbers 0..127, middle C is 60
// - velocity 1..127; zero velocity means note off
// - program change gives 128 program numbers
// - controllers 32..63 are low bytes of 0..31
// - switch controllers take only 0 or 127
// - continuous controllers carry full 0..127 range
// - decode nrpn, rpn, data increment and decrement
// - controllers 121..127 are channel mode commands
// - mono on count 0..16, zero means omni off
// - omni on: accept every channel
// - omni off: accept only the selected channel
// - system messages pass without channel filter
// - output switchable between own data and echo
// - each timing clock while running advances one 24th quarter
// - song position counts sixteenths, up to 16384; the 14-bit beat_pos_q holds at most 16383
// - start rewinds, stop halts, continue resumes
// - act only on own maker system exclusive
module midi_message_interpreter
  import midi_pkg::*;
#(
  parameter logic [6:0] MAKER_ID = 7'h55, // arbitrary value
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // received bytes from the uart
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_byte,
  // configuration
  input wire logic thru_en,
  input wire logic [3:0] base_chan,
  // own generated bytes
  input wire logic gen_valid,
  output logic gen_ready,
  input wire logic [7:0] gen_byte,
  // bytes to the uart transmitter
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_byte,
  // voice events
  output logic note_on_q,
  output logic note_off_q,
  output logic [6:0] note_num_q,
  output logic [6:0] note_vel_q,
  output logic prog_q,
  output logic [6:0] prog_num_q,
  output logic [3:0] msg_chan_q,
  // controller events
  output logic ctrl_q,
  output logic [6:0] ctrl_num_q,
  output logic [6:0] ctrl_val_q,
  output logic ctrl_lsb_q,
  output logic switch_on_q,
  output logic param_q,
  output param_sel_t param_sel_q,
  // channel mode
  output logic mode_q,
  output mode_cmd_t mode_sel_q,
  output logic omni_q,
  output logic mono_q,
  output logic [4:0] mono_count_q,
  output logic local_q,
  // transport
  output logic tick_q,
  output logic running_q,
  output logic [13:0] beat_pos_q,
  output logic [2:0] sub_pos_q,
  // own system exclusive data
  output logic sx_valid_q,
  output logic [6:0] sx_byte_q
);
  localparam logic [2:0] SUB_LAST = 3'(`MIDI_CLK_PER_QN / `MIDI_BEATS_PER_QN - 1);

  // ==========================================================
  // input buffer and output switch
  logic fifo_valid;
  logic [7:0] b;
  logic take;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_byte),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data(b)
  );

  // echo stalls parsing so that no byte is parsed without being passed on
  assign take = fifo_valid && (!thru_en || tx_ready);
  assign tx_valid = thru_en ? fifo_valid : gen_valid;
  assign tx_byte = thru_en ? b : gen_byte;
  assign gen_ready = !thru_en && tx_ready;

  // ==========================================================
  // byte classification
  logic [7:0] status_q;
  logic [6:0] data1_q;
  logic have1_q;
  sx_state_t sx_st_q;
  logic is_rt;
  logic is_stat;
  logic need1;
  logic cmplt;
  logic chan_ok;
  logic voice;
  logic [6:0] d1;
  logic [6:0] d2;

  assign is_rt = take && b[7:3] == `MIDI_RT_PREFIX;
  assign is_stat = take && b[7] && !is_rt;
  assign need1 = status_q[7:4] == `MIDI_PROG || status_q[7:4] == `MIDI_PRESS ||
    status_q == `MIDI_TC_QUARTER || status_q == `MIDI_SONG_SEL;
  assign cmplt = take && !b[7] && sx_st_q == sx_idle && status_q[7] && (need1 || have1_q);
  assign d1 = need1 ? b[6:0] : data1_q;
  assign d2 = b[6:0];
  assign chan_ok = omni_q || status_q[3:0] == base_chan;
  assign voice = cmplt && status_q[7:4] != `MIDI_SYSTEM && chan_ok;

  // ==========================================================
  // running status parser; real time bytes never touch it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_q <= 8'h00;
      data1_q <= 7'h00;
      have1_q <= 1'b0;
    end else if (is_stat) begin
      // system common status cancels running status
      status_q <= (b[7:4] == `MIDI_SYSTEM && b != `MIDI_SONG_POS && b != `MIDI_TC_QUARTER &&
        b != `MIDI_SONG_SEL) ? 8'h00 : b;
      have1_q <= 1'b0;
    end else if (take && !b[7] && sx_st_q == sx_idle && status_q[7]) begin
      if (cmplt) begin
        have1_q <= 1'b0;
        if (status_q[7:4] == `MIDI_SYSTEM) begin
          status_q <= 8'h00;
        end
      end else begin
        data1_q <= b[6:0];
        have1_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // voice messages
  always_ff @(posedge core_clk) begin
    if (srst) begin
      note_on_q <= 1'b0;
      note_off_q <= 1'b0;
      note_num_q <= 7'h00;
      note_vel_q <= 7'h00;
      prog_q <= 1'b0;
      prog_num_q <= 7'h00;
      msg_chan_q <= 4'h0;
    end else begin
      note_on_q <= 1'b0;
      note_off_q <= 1'b0;
      prog_q <= 1'b0;
      if (voice) begin
        msg_chan_q <= status_q[3:0];
        unique case (status_q[7:4])
          `MIDI_NOTE_ON, `MIDI_NOTE_OFF: begin
            note_num_q <= d1;
            note_vel_q <= d2;
            note_on_q <= status_q[7:4] == `MIDI_NOTE_ON && d2 != `MIDI_VEL_OFF;
            note_off_q <= status_q[7:4] == `MIDI_NOTE_OFF || d2 == `MIDI_VEL_OFF;
          end
          `MIDI_PROG: begin
            prog_q <= 1'b1;
            prog_num_q <= d1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // controllers; numbers 102..120 are unassigned and dropped
  logic is_ctrl;
  assign is_ctrl = voice && status_q[7:4] == `MIDI_CTRL;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= 1'b0;
      ctrl_num_q <= 7'h00;
      ctrl_val_q <= 7'h00;
      ctrl_lsb_q <= 1'b0;
      switch_on_q <= 1'b0;
      param_q <= 1'b0;
      param_sel_q <= par_nrpn_msb;
    end else begin
      ctrl_q <= 1'b0;
      param_q <= 1'b0;
      if (is_ctrl && (d1 <= `CC_RPN_LSB)) begin
        ctrl_q <= 1'b1;
        ctrl_num_q <= d1;
        ctrl_val_q <= d2;
        ctrl_lsb_q <= d1 >= `CC_LSB_FIRST && d1 <= `CC_LSB_LAST;
        // anything short of full scale counts as off
        switch_on_q <= d2 == `MIDI_VAL_MAX;
        if (d1 >= `CC_DATA_INC) begin
          param_q <= 1'b1;
          unique case (d1)
            `CC_DATA_INC: param_sel_q <= par_inc;
            `CC_DATA_DEC: param_sel_q <= par_dec;
            `CC_NRPN_MSB: param_sel_q <= par_nrpn_msb;
            `CC_NRPN_LSB: param_sel_q <= par_nrpn_lsb;
            `CC_RPN_MSB: param_sel_q <= par_rpn_msb;
            default: param_sel_q <= par_rpn_lsb;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // channel mode commands
  logic is_mode;
  assign is_mode = is_ctrl && d1 >= `CC_MODE_FIRST;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_q <= 1'b0;
      mode_sel_q <= mode_reset_all;
      omni_q <= 1'b1;
      mono_q <= 1'b0;
      mono_count_q <= 5'h00;
      local_q <= 1'b1;
    end else begin
      mode_q <= 1'b0;
      if (is_mode && !(d1 == `CC_MONO_ON && d2 > `MIDI_MONO_MAX)) begin
        mode_q <= 1'b1;
        unique case (d1)
          `CC_RESET_ALL: mode_sel_q <= mode_reset_all;
          `CC_LOCAL: begin
            mode_sel_q <= mode_local;
            local_q <= d2 == `MIDI_VAL_MAX;
          end
          `CC_ALL_OFF: mode_sel_q <= mode_all_off;
          `CC_OMNI_OFF: begin
            mode_sel_q <= mode_omni_off;
            omni_q <= 1'b0;
          end
          `CC_OMNI_ON: begin
            mode_sel_q <= mode_omni_on;
            omni_q <= 1'b1;
          end
          `CC_MONO_ON: begin
            mode_sel_q <= mode_mono_on;
            mono_q <= 1'b1;
            mono_count_q <= d2[4:0];
            if (d2 == 7'h00) begin
              omni_q <= 1'b0;
            end
          end
          default: begin
            mode_sel_q <= mode_poly_on;
            mono_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // transport; clocks count only while running
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_q <= 1'b0;
      running_q <= 1'b0;
      beat_pos_q <= 14'h0000;
      sub_pos_q <= 3'h0;
    end else begin
      tick_q <= is_rt && b == `MIDI_CLOCK;
      if (is_rt) begin
        unique case (b)
          `MIDI_CLOCK: begin
            if (running_q) begin
              if (sub_pos_q == SUB_LAST) begin
                sub_pos_q <= 3'h0;
                beat_pos_q <= beat_pos_q + 14'h0001;
              end else begin
                sub_pos_q <= sub_pos_q + 3'h1;
              end
            end
          end
          `MIDI_START: begin
            running_q <= 1'b1;
            beat_pos_q <= 14'h0000;
            sub_pos_q <= 3'h0;
          end
          `MIDI_CONTINUE: running_q <= 1'b1;
          `MIDI_STOP: running_q <= 1'b0;
          default: begin
          end
        endcase
      end else if (cmplt && status_q == `MIDI_SONG_POS) begin
        beat_pos_q <= {d2, d1};
        sub_pos_q <= 3'h0;
      end
    end
  end

  // ==========================================================
  // system exclusive filter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sx_st_q <= sx_idle;
      sx_valid_q <= 1'b0;
      sx_byte_q <= 7'h00;
    end else begin
      sx_valid_q <= 1'b0;
      if (is_stat) begin
        sx_st_q <= (b == `MIDI_SX_START) ? sx_id : sx_idle;
      end else if (take && !b[7]) begin
        unique case (sx_st_q)
          sx_id: sx_st_q <= (b[6:0] == MAKER_ID) ? sx_take : sx_skip;
          sx_take: begin
            sx_valid_q <= 1'b1;
            sx_byte_q <= b[6:0];
          end
          sx_skip, sx_idle: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  property p_vel_zero;
    @(posedge core_clk) disable iff (srst) note_on_q |-> note_vel_q != 7'h00 && !note_off_q;
  endproperty
  a_vel_zero: assert property (p_vel_zero) else $error("note on with zero velocity");

  property p_zero_is_off;
    @(posedge core_clk) disable iff (srst)
      (voice && status_q[7:4] == `MIDI_NOTE_ON && d2 == 7'h00) |=> note_off_q && note_num_q == $past(d1);
  endproperty
  a_zero_is_off: assert property (p_zero_is_off) else $error("zero velocity not a note off");

  property p_chan_filter;
    @(posedge core_clk) disable iff (srst)
      ((note_on_q || note_off_q || prog_q || ctrl_q) && !$past(omni_q)) |-> msg_chan_q == $past(base_chan);
  endproperty
  a_chan_filter: assert property (p_chan_filter) else $error("foreign channel accepted");

  property p_lsb_pair;
    @(posedge core_clk) disable iff (srst)
      ctrl_q |-> ctrl_lsb_q == (ctrl_num_q >= `CC_LSB_FIRST && ctrl_num_q <= `CC_LSB_LAST);
  endproperty
  a_lsb_pair: assert property (p_lsb_pair) else $error("low byte pairing wrong");

  property p_mono_zero;
    @(posedge core_clk) disable iff (srst) (is_mode && d1 == `CC_MONO_ON && d2 == 7'h00) |=> !omni_q && mono_q;
  endproperty
  a_mono_zero: assert property (p_mono_zero) else $error("mono zero kept omni");

  property p_tick_wrap;
    @(posedge core_clk) disable iff (srst) (is_rt && b == `MIDI_CLOCK && running_q && sub_pos_q == SUB_LAST)
      |=> sub_pos_q == 3'h0 && beat_pos_q == $past(beat_pos_q) + 14'h0001;
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("beat not advanced");

  property p_start;
    @(posedge core_clk) disable iff (srst) (is_rt && b == `MIDI_START) |=> running_q && beat_pos_q == 14'h0000;
  endproperty
  a_start: assert property (p_start) else $error("start did not rewind");

  property p_stop_hold;
    @(posedge core_clk) disable iff (srst) (is_rt && b == `MIDI_STOP) |=> !running_q && $stable(beat_pos_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop moved position");

  property p_song_pos;
    @(posedge core_clk) disable iff (srst)
      (cmplt && status_q == `MIDI_SONG_POS) |=> beat_pos_q == {$past(d2), $past(d1)};
  endproperty
  a_song_pos: assert property (p_song_pos) else $error("song position not loaded");

  property p_sx_own;
    @(posedge core_clk) disable iff (srst) sx_valid_q |-> $past(sx_st_q) == sx_take;
  endproperty
  a_sx_own: assert property (p_sx_own) else $error("foreign exclusive data passed");

  property p_echo;
    @(posedge core_clk) disable iff (srst) thru_en |-> !gen_ready && (take == (fifo_valid && tx_ready));
  endproperty
  a_echo: assert property (p_echo) else $error("echo path wrong");

  c_note: cover property (@(posedge core_clk) disable iff (srst) note_on_q ##[1:50] note_off_q);
  c_sx: cover property (@(posedge core_clk) disable iff (srst) sx_valid_q);
  c_tick: cover property (@(posedge core_clk) disable iff (srst) tick_q && running_q && sub_pos_q == 3'h0);
  c_echo: cover property (@(posedge core_clk) disable iff (srst) thru_en && take);
endmodule : midi_message_interpreter

// *** bench/midi_instrument_model.sv ***
// instrument model: feeds bytes to the interpreter and takes its output bytes
`timescale 1ns/1ps
module midi_instrument_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bytes toward the interpreter
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_byte,
  // bytes back from the interpreter
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_byte,
  // far side stall
  input wire logic stall
);
  logic [7:0] pend[$];
  logic [7:0] seen[$];
  int acc_count = 0;
  assign tx_ready = !stall;
  // =====================================
  // byte source
  // an offer holds until taken; idle data toggles so nothing stale looks valid
  always @(posedge core_clk) begin
    if (srst) begin
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      if (rx_valid && rx_ready) begin
        acc_count++;
      end
      if (!rx_valid || rx_ready) begin
        if (pend.size() != 0) begin
          rx_valid <= 1'b1;
          rx_byte <= pend.pop_front();
        end else begin
          rx_valid <= 1'b0;
          rx_byte <= ~rx_byte;
        end
      end
    end
  end
  // =====================================
  // byte sink
  always @(posedge core_clk) begin
    if (!srst && tx_valid && tx_ready) begin
      seen.push_back(tx_byte);
    end
  end
endmodule : midi_instrument_model

// *** bench/tb_midi_message_interpreter.sv ***
// self-checking bench of the midi message interpreter
`timescale 1ns/1ps
module tb_midi_message_interpreter
  import midi_pkg::*;
;
  typedef logic [7:0] bytes_t[$];
  logic core_clk = 1'b0, srst = 1'b1, thru_en = 1'b0, gen_valid = 1'b0, stall = 1'b0;
  logic [3:0] base_chan = 4'h0;
  logic [7:0] gen_byte = 8'h00;
  logic rx_valid, rx_ready, gen_ready, tx_valid, tx_ready, note_on_q, note_off_q, prog_q, ctrl_q, ctrl_lsb_q;
  logic switch_on_q, param_q, mode_q, omni_q, mono_q, local_q, tick_q, running_q, sx_valid_q;
  logic [7:0] rx_byte, tx_byte;
  logic [6:0] note_num_q, note_vel_q, prog_num_q, ctrl_num_q, ctrl_val_q, sx_byte_q;
  logic [3:0] msg_chan_q;
  param_sel_t param_sel_q;
  mode_cmd_t mode_sel_q;
  logic [4:0] mono_count_q;
  logic [13:0] beat_pos_q;
  logic [2:0] sub_pos_q;
  int bad_count = 0, checks = 0, cycles = 0;
  int cnt[8], base[8];
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  midi_message_interpreter midi_message_interpreter_i (.core_clk(core_clk), .srst(srst), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .thru_en(thru_en), .base_chan(base_chan), .gen_valid(gen_valid),
    .gen_ready(gen_ready), .gen_byte(gen_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .note_on_q(note_on_q), .note_off_q(note_off_q), .note_num_q(note_num_q), .note_vel_q(note_vel_q),
    .prog_q(prog_q), .prog_num_q(prog_num_q), .msg_chan_q(msg_chan_q), .ctrl_q(ctrl_q), .ctrl_num_q(ctrl_num_q),
    .ctrl_val_q(ctrl_val_q), .ctrl_lsb_q(ctrl_lsb_q), .switch_on_q(switch_on_q), .param_q(param_q),
    .param_sel_q(param_sel_q), .mode_q(mode_q), .mode_sel_q(mode_sel_q), .omni_q(omni_q), .mono_q(mono_q),
    .mono_count_q(mono_count_q), .local_q(local_q), .tick_q(tick_q), .running_q(running_q),
    .beat_pos_q(beat_pos_q), .sub_pos_q(sub_pos_q), .sx_valid_q(sx_valid_q), .sx_byte_q(sx_byte_q));
  midi_instrument_model midi_instrument_model_i (.core_clk(core_clk), .srst(srst), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .stall(stall));
  // =====================================
  // event counters: 0 on, 1 off, 2 prog, 3 ctrl, 4 param, 5 mode, 6 tick, 7 sx
  always @(posedge core_clk) begin
    cycles++;
    if (!srst) begin
      cnt[0] += int'(note_on_q === 1'b1);
      cnt[1] += int'(note_off_q === 1'b1);
      cnt[2] += int'(prog_q === 1'b1);
      cnt[3] += int'(ctrl_q === 1'b1);
      cnt[4] += int'(param_q === 1'b1);
      cnt[5] += int'(mode_q === 1'b1);
      cnt[6] += int'(tick_q === 1'b1);
      cnt[7] += int'(sx_valid_q === 1'b1);
    end
    // long enough for every scenario several times over
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // =====================================
  // compare and stimulus tasks
  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val
  task automatic check_cnt(input string name, input int idx, input int exp);
    checks++;
    if (cnt[idx] - base[idx] != exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, cnt[idx] - base[idx]);
    end
  endtask : check_cnt
  // queue a message, then wait for the byte source to drain and the parser latency to pass
  task automatic msg(input bytes_t m);
    int n;
    @(negedge core_clk);
    base = cnt;
    foreach (m[i]) begin
      midi_instrument_model_i.pend.push_back(m[i]);
    end
    n = 0;
    while ((midi_instrument_model_i.pend.size() != 0 || rx_valid !== 1'b0) && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    repeat (6) @(posedge core_clk);
  endtask : msg
  task automatic tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // =====================================
  // scenarios
  task automatic s_notes();
    msg({8'h90, 8'h3c, 8'h40});
    check_cnt("note on", 0, 1);
    check_val("note num", 16'h3c, 16'(note_num_q));
    check_val("note vel", 16'h40, 16'(note_vel_q));
    msg({8'h7f, 8'h7f, 8'h80, 8'h00, 8'h01});
    check_cnt("note on running", 0, 1);
    check_cnt("note off", 1, 1);
    check_val("note num low", 16'h00, 16'(note_num_q));
    msg({8'h90, 8'h3c, 8'h00});
    check_cnt("zero vel on", 0, 0);
    check_cnt("zero vel off", 1, 1);
  endtask : s_notes
  task automatic s_ctrl();
    param_sel_t ps[6] = '{par_inc, par_dec, par_nrpn_msb, par_nrpn_lsb, par_rpn_msb, par_rpn_lsb};
    msg({8'hc0, 8'h7f});
    check_val("program", 16'h7f, 16'(prog_num_q));
    check_cnt("prog pulse", 2, 1);
    msg({8'hb0, 8'h21, 8'h05});
    check_val("lsb flag", 16'h1, 16'(ctrl_lsb_q));
    msg({8'hb0, 8'h40, 8'h7f});
    check_val("switch on", 16'h1, 16'(switch_on_q));
    msg({8'hb0, 8'h40, 8'h00});
    check_val("switch off", 16'h0, 16'(switch_on_q));
    msg({8'hb0, 8'h07, 8'h7f});
    check_val("ctrl num", 16'h07, 16'(ctrl_num_q));
    check_val("ctrl val", 16'h7f, 16'(ctrl_val_q));
    check_cnt("ctrl pulse", 3, 1);
    check_val("msb flag", 16'h0, 16'(ctrl_lsb_q));
    for (int i = 0; i < 6; i++) begin
      msg({8'hb0, 8'h60 + 8'(i), 8'h11});
      check_cnt("param pulse", 4, 1);
      check_val("param sel", 16'(ps[i]), 16'(param_sel_q));
    end
  endtask : s_ctrl
  task automatic s_modes();
    logic [7:0] mv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    for (int i = 0; i < 7; i++) begin
      msg({8'hb0, 8'h79 + 8'(i), mv[i]});
      check_cnt("mode pulse", 5, 1);
      check_val("mode sel", 16'(i), 16'(mode_sel_q));
      if (i == 5) check_val("mono count", 16'h3, 16'(mono_count_q));
    end
    msg({8'hb0, 8'h7a, 8'h7f});
    check_val("local on", 16'h1, 16'(local_q));
    msg({8'hb0, 8'h7e, 8'h00});
    check_val("mono zero omni", 16'h0, 16'(omni_q));
    check_val("mono zero mono", 16'h1, 16'(mono_q));
    msg({8'hb0, 8'h7e, 8'h11});
    check_cnt("mono over range", 5, 0);
    msg({8'hb0, 8'h7d, 8'h00, 8'h7f, 8'h00});
    check_val("poly clears mono", 16'h0, 16'(mono_q));
  endtask : s_modes
  task automatic s_channels();
    msg({8'h95, 8'h30, 8'h20});
    check_val("omni chan", 16'h5, 16'(msg_chan_q));
    @(posedge core_clk) base_chan <= 4'h2;
    msg({8'hb2, 8'h7c, 8'h00});
    check_val("omni off", 16'h0, 16'(omni_q));
    msg({8'h95, 8'h31, 8'h20, 8'hf8});
    check_cnt("other chan", 0, 0);
    check_cnt("clock unfiltered", 6, 1);
    msg({8'h92, 8'h32, 8'h20});
    check_cnt("own chan", 0, 1);
    msg({8'hb2, 8'h7d, 8'h00});
  endtask : s_channels
  task automatic s_transport();
    bytes_t clk24;
    for (int i = 0; i < 24; i++) clk24.push_back(8'hf8);
    msg({8'hfa});
    msg(clk24);
    check_val("beat after quarter", 16'h4, 16'(beat_pos_q));
    check_val("sub after quarter", 16'h0, 16'(sub_pos_q));
    msg({8'hfc, 8'hf8, 8'hf8, 8'hf8});
    check_cnt("ticks when stopped", 6, 3);
    check_val("stopped beat", 16'h4, 16'(beat_pos_q));
    msg({8'hfb, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8, 8'hf8});
    check_val("continue beat", 16'h5, 16'(beat_pos_q));
    check_val("continue sub", 16'h1, 16'(sub_pos_q));
    msg({8'hfc, 8'hf2, 8'h7f, 8'h7f});
    check_val("song pos max", 16'h3fff, 16'(beat_pos_q));
    msg({8'hf2, 8'h02, 8'h01});
    check_val("song pos pair", 16'h0082, 16'(beat_pos_q));
    msg({8'hfa});
    check_val("start rewinds", 16'h0, 16'(beat_pos_q));
    check_val("running", 16'h1, 16'(running_q));
  endtask : s_transport
  task automatic s_sysex_and_junk();
    msg({8'hf0, 8'h55, 8'h01, 8'hf8, 8'h02, 8'hf7});
    check_cnt("own sysex", 7, 2);
    check_val("sysex byte", 16'h02, 16'(sx_byte_q));
    msg({8'hf0, 8'h12, 8'h01, 8'h02, 8'hf7});
    check_cnt("other sysex", 7, 0);
    msg({8'he0, 8'h01, 8'h02, 8'hb0, 8'h70, 8'h05, 8'hd0, 8'h05, 8'hf3, 8'h05, 8'h90, 8'h30, 8'hf8, 8'h50});
    check_cnt("dropped ctrl", 3, 0);
    check_cnt("note after junk", 0, 1);
    check_val("note vel after rt", 16'h50, 16'(note_vel_q));
  endtask : s_sysex_and_junk
  task automatic s_thru();
    int a0, s0, n;
    @(posedge core_clk);
    thru_en <= 1'b1;
    stall <= 1'b1;
    @(negedge core_clk);
    a0 = midi_instrument_model_i.acc_count;
    s0 = midi_instrument_model_i.seen.size();
    midi_instrument_model_i.pend.push_back(8'hf6);
    for (int i = 0; i < 19; i++) midi_instrument_model_i.pend.push_back(8'(i));
    n = 0;
    while (rx_ready !== 1'b0 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    repeat (3) @(negedge core_clk);
    check_val("fifo full count", 16'd16, 16'(midi_instrument_model_i.acc_count - a0));
    check_val("fifo refuses", 16'h0, 16'(rx_ready));
    @(posedge core_clk) stall <= 1'b0;
    repeat (40) @(posedge core_clk);
    check_val("echo count", 16'd20, 16'(midi_instrument_model_i.seen.size() - s0));
    check_val("echo first", 16'hf6, 16'(midi_instrument_model_i.seen[s0]));
    for (int i = 0; i < 19; i++) begin
      check_val("echo byte", 16'(i), 16'(midi_instrument_model_i.seen[s0 + 1 + i]));
    end
    @(posedge core_clk);
    thru_en <= 1'b0;
    gen_valid <= 1'b1;
    gen_byte <= 8'ha5;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (gen_ready !== 1'b1 && n < 50);
    gen_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    check_val("own data out", 16'ha5, 16'(midi_instrument_model_i.seen[$]));
  endtask : s_thru
  // =====================================
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check_val("reset omni", 16'h1, 16'(omni_q));
    check_val("reset local", 16'h1, 16'(local_q));
    check_val("reset rx ready", 16'h1, 16'(rx_ready));
    s_notes();
    s_ctrl();
    s_modes();
    s_channels();
    s_transport();
    s_sysex_and_junk();
    s_thru();
    tally_and_finish();
  end
endmodule : tb_midi_message_interpreter
